// File: usf_status_irq.sv
// Status flags, interrupt mask and interrupt line of one serial channel.
// Assumes command strobes and event pulses come from logic on i_clk_sys;
// only the modem pins arrive asynchronously and are synchronised here.
//
// How it works
// (RULE_01) Write-only enable register sets mask bits 0-13 and 16-19.
// (RULE_02) Write-only disable register, same layout, targets the same sources.
// (RULE_03) Read-only mask register shows which sources are enabled.
// (RULE_04) Ones set or clear mask bits; interrupt while status and mask share a one.
// (RULE_05) Receive ready after a complete character until holding read; zero while disabled.
// (RULE_06) A pending character shows receive ready again once the receiver is re-enabled.
// (RULE_07) Transmit ready low for full holding register, pending break start, or disabled.
// (RULE_08) Transmit ready rises as soon as the transmitter is enabled.
// (RULE_09) Break flag set on break or break end, held until status clear.
// (RULE_10) Receive and transmit DMA end flags mirror the DMA channel signals.
// (RULE_11) Buffer full and buffer empty flags mirror the DMA channel signals.
// (RULE_12) Overrun flag sticky until status clear.
// (RULE_13) Framing flag set on a low stop bit, sticky until status clear.
// (RULE_14) Parity flag sticky until status clear.
// (RULE_15) Timeout flag set by time-out after arming; zero when time-out value is zero.
// (RULE_16) Drained flag only when holding and shift registers empty; zero while disabled.
// (RULE_17) Repeat-limit flag sticky until status clear.
// (RULE_18) Negative acknowledge flag sticky until its own clear command.
// (RULE_19) Modem change flags set on any pin change, cleared by a status read.
// (RULE_20) Status bits 20-23 carry the modem pin images; status is read-only.
// (RULE_21) Each image bit is the current pin level.
// (RULE_22) Status clear resets parity, framing, overrun and break together.
// (RULE_23) Timeout arm clears the timeout flag; receiver waits for a character.
// (RULE_24) Software clears sticky errors before trusting them for a new reception.
`timescale 1ns/1ps

module usf_status_irq (
    input wire logic i_clk_sys, // Peripheral clock, 200 MHz
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic [31:0] i_addr, // Register byte address
    input wire logic [31:0] i_wr_data, // Register write data
    input wire logic i_wr_en, // Write strobe, one cycle
    input wire logic i_rd_en, // Read strobe, one cycle
    output logic [31:0] o_rd_data, // Read data, cycle after strobe only
    output logic o_irq, // Interrupt request, active high
    input wire logic i_rx_enabled, // Receiver enabled level
    input wire logic i_tx_enabled, // Transmitter enabled level
    input wire logic i_rx_char_done, // Complete character received pulse
    input wire logic i_rx_holding_read, // Receive holding register read pulse
    input wire logic i_tx_holding_full, // Transmit holding register occupied
    input wire logic i_tx_shift_busy, // Transmit shift register occupied
    input wire logic i_break_start_cmd, // Break start command pulse
    input wire logic i_break_started, // Transmitter began the break pulse
    input wire logic i_rx_break_seen, // Break or end of break pulse
    input wire logic i_rx_overrun_err, // Overrun pulse
    input wire logic i_rx_frame_err, // Stop bit sampled low pulse
    input wire logic i_parity_err, // Parity error pulse
    input wire logic i_rx_timeout, // Receiver time-out pulse
    input wire logic i_timeout_zero, // Time-out value register is zero
    input wire logic i_repeat_limit_hit, // Repetition limit reached pulse
    input wire logic i_neg_ack_seen, // Negative acknowledge pulse
    input wire logic i_status_clear_cmd, // Status clear command pulse
    input wire logic i_timeout_arm_cmd, // Timeout arm command pulse
    input wire logic i_neg_ack_clear_cmd, // Negative acknowledge clear pulse
    input wire logic i_rx_dma_end, // Receive DMA end of transfer
    input wire logic i_tx_dma_end, // Transmit DMA end of transfer
    input wire logic i_rx_dma_buffer_full, // Receive DMA buffer full
    input wire logic i_tx_dma_buffer_empty, // Transmit DMA buffer empty
    input wire logic [3:0] i_modem_pins // Ring, set ready, carrier, clear to send
);

    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] sticky_q;
    logic [31:0] sticky_d;
    logic [31:0] sticky_set;
    logic [31:0] sticky_clr;
    logic [31:0] status_now;
    logic [31:0] rd_data_d;
    logic break_pend_q;
    logic [2:0] prime_q;
    logic [3:0] modem_s1_q;
    logic [3:0] modem_s2_q;
    logic [3:0] modem_prev_q;

    // Address decode
    wire hit_set = i_wr_en && (i_addr == usf_pkg::ADDR_IRQ_SET);
    wire hit_clr = i_wr_en && (i_addr == usf_pkg::ADDR_IRQ_CLR);
    wire rd_mask = i_rd_en && (i_addr == usf_pkg::ADDR_MASK);
    wire rd_status = i_rd_en && (i_addr == usf_pkg::ADDR_STATUS);
    wire modem_primed = prime_q[2];
    wire [3:0] modem_change = (modem_s2_q ^ modem_prev_q) & {4{modem_primed}};

    // Level flags formed from the engines' state plus sticky and break-pending bits, not registered
    wire tx_free = i_tx_enabled && !i_tx_holding_full && !break_pend_q; // RULE_07 RULE_08
    wire tx_drained = i_tx_enabled && !i_tx_holding_full && !i_tx_shift_busy; // RULE_16
    wire rx_ready = sticky_q[usf_pkg::BIT_RX_READY] && i_rx_enabled; // RULE_05 RULE_06
    wire timeout_seen = sticky_q[usf_pkg::BIT_TIMEOUT] && !i_timeout_zero; // RULE_15

    // Mask update: ones set or clear, zeros leave bits alone
    assign mask_d = hit_set ? (mask_q | (i_wr_data & usf_pkg::MASK_VALID)) : // RULE_01 RULE_04
                    hit_clr ? (mask_q & ~i_wr_data) : // RULE_02 RULE_04
                    mask_q;

    // Event sources into the sticky bits
    always_comb begin
        sticky_set = usf_pkg::STICKY_RST;
        sticky_set[usf_pkg::BIT_RX_READY] = i_rx_char_done; // RULE_05
        sticky_set[usf_pkg::BIT_BREAK] = i_rx_break_seen; // RULE_09
        sticky_set[usf_pkg::BIT_OVERRUN] = i_rx_overrun_err; // RULE_12
        sticky_set[usf_pkg::BIT_FRAME] = i_rx_frame_err; // RULE_13
        sticky_set[usf_pkg::BIT_PARITY] = i_parity_err; // RULE_14
        sticky_set[usf_pkg::BIT_TIMEOUT] = i_rx_timeout; // RULE_15
        sticky_set[usf_pkg::BIT_REPEAT] = i_repeat_limit_hit; // RULE_17
        sticky_set[usf_pkg::BIT_NEG_ACK] = i_neg_ack_seen; // RULE_18
        sticky_set[usf_pkg::BIT_CHG_LSB +: usf_pkg::MODEM_LANES] = modem_change; // RULE_19
    end

    // Clear sources; the receive-ready bit is not cleared by disabling,
    // so a character caught before disable shows again after enable
    always_comb begin
        sticky_clr = usf_pkg::STICKY_RST;
        sticky_clr[usf_pkg::BIT_RX_READY] = i_rx_holding_read; // RULE_05 RULE_06
        sticky_clr[usf_pkg::BIT_BREAK] = i_status_clear_cmd; // RULE_09 RULE_22
        sticky_clr[usf_pkg::BIT_OVERRUN] = i_status_clear_cmd; // RULE_12 RULE_22
        sticky_clr[usf_pkg::BIT_FRAME] = i_status_clear_cmd; // RULE_13 RULE_22
        sticky_clr[usf_pkg::BIT_PARITY] = i_status_clear_cmd; // RULE_14 RULE_22
        sticky_clr[usf_pkg::BIT_TIMEOUT] = i_timeout_arm_cmd; // RULE_23
        sticky_clr[usf_pkg::BIT_REPEAT] = i_status_clear_cmd; // RULE_17
        sticky_clr[usf_pkg::BIT_NEG_ACK] = i_neg_ack_clear_cmd; // RULE_18
        sticky_clr[usf_pkg::BIT_CHG_LSB +: usf_pkg::MODEM_LANES] = {4{rd_status}}; // RULE_19
    end

    // One sticky cell per bit; a set in the clearing cycle wins so no event is lost
    for (genvar b = 0; b < 32; b++) begin : g_sticky
        assign sticky_d[b] = usf_pkg::STICKY_BITS[b] && (sticky_set[b] || (sticky_q[b] && !sticky_clr[b]));
    end

    // Assemble the status word as software sees it
    always_comb begin
        status_now = usf_pkg::DATA_ZERO;
        status_now[usf_pkg::BIT_RX_READY] = rx_ready; // RULE_05
        status_now[usf_pkg::BIT_TX_FREE] = tx_free; // RULE_07
        status_now[usf_pkg::BIT_BREAK] = sticky_q[usf_pkg::BIT_BREAK]; // RULE_09
        status_now[usf_pkg::BIT_RX_DMA_END] = i_rx_dma_end; // RULE_10
        status_now[usf_pkg::BIT_TX_DMA_END] = i_tx_dma_end; // RULE_10
        status_now[usf_pkg::BIT_OVERRUN] = sticky_q[usf_pkg::BIT_OVERRUN]; // RULE_12
        status_now[usf_pkg::BIT_FRAME] = sticky_q[usf_pkg::BIT_FRAME]; // RULE_13
        status_now[usf_pkg::BIT_PARITY] = sticky_q[usf_pkg::BIT_PARITY]; // RULE_14
        status_now[usf_pkg::BIT_TIMEOUT] = timeout_seen; // RULE_15
        status_now[usf_pkg::BIT_TX_DRAINED] = tx_drained; // RULE_16
        status_now[usf_pkg::BIT_REPEAT] = sticky_q[usf_pkg::BIT_REPEAT]; // RULE_17
        status_now[usf_pkg::BIT_TX_BUF_EMPTY] = i_tx_dma_buffer_empty; // RULE_11
        status_now[usf_pkg::BIT_RX_BUF_FULL] = i_rx_dma_buffer_full; // RULE_11
        status_now[usf_pkg::BIT_NEG_ACK] = sticky_q[usf_pkg::BIT_NEG_ACK]; // RULE_18
        status_now[usf_pkg::BIT_CHG_LSB +: usf_pkg::MODEM_LANES] =
            sticky_q[usf_pkg::BIT_CHG_LSB +: usf_pkg::MODEM_LANES]; // RULE_19
        status_now[usf_pkg::BIT_IMG_LSB +: usf_pkg::MODEM_LANES] = modem_s2_q; // RULE_20 RULE_21
    end

    // Read mux; write-only and unmapped addresses read as zero
    assign rd_data_d = rd_mask ? mask_q : // RULE_03
                       rd_status ? status_now : // RULE_20
                       usf_pkg::DATA_ZERO;

    // Register state; writes to the status address are ignored
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_q <= usf_pkg::MASK_RST;
            sticky_q <= usf_pkg::STICKY_RST;
        end else begin
            mask_q <= mask_d;
            sticky_q <= sticky_d;
        end
    end

    // Break start stays pending until the transmitter takes it or is disabled
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            break_pend_q <= 1'b0;
        end else if (i_break_start_cmd) begin
            break_pend_q <= 1'b1; // RULE_07
        end else if (i_break_started || !i_tx_enabled) begin
            break_pend_q <= 1'b0;
        end
    end

    // Modem pins: two-stage synchroniser, then a previous-value copy.
    // The prime counter hides the bogus change right after reset.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            modem_s1_q <= usf_pkg::MODEM_RST;
            modem_s2_q <= usf_pkg::MODEM_RST;
            modem_prev_q <= usf_pkg::MODEM_RST;
            prime_q <= usf_pkg::PRIME_RST;
        end else begin
            modem_s1_q <= i_modem_pins;
            modem_s2_q <= modem_s1_q; // RULE_21
            modem_prev_q <= modem_s2_q;
            prime_q <= {prime_q[1:0], 1'b1};
        end
    end

    // Outputs straight from flops; read data lives one cycle only
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= usf_pkg::DATA_ZERO;
            o_irq <= 1'b0;
        end else begin
            o_rd_data <= rd_data_d;
            o_irq <= |(status_now & mask_q); // RULE_04
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    a_mask_set_bits: assert property (hit_set |=> ((mask_q & $past(i_wr_data) & usf_pkg::MASK_VALID) // RULE_01
        == ($past(i_wr_data) & usf_pkg::MASK_VALID)))
        else $error("enable write did not set mask bits");

    a_mask_clr_bits: assert property (hit_clr |=> ((mask_q & $past(i_wr_data)) == 32'h0000_0000)) // RULE_02
        else $error("disable write did not clear mask bits");

    a_mask_readback: assert property (rd_mask |=> (o_rd_data == $past(mask_q))) // RULE_03
        else $error("mask read returned wrong value");

    a_irq_quiet_mask: assert property ((mask_q == 32'h0000_0000)[*2] |-> !o_irq) // RULE_04
        else $error("interrupt raised with empty mask");

    a_rx_ready_set: assert property ((i_rx_char_done && i_rx_enabled) ##1 i_rx_enabled |-> rx_ready) // RULE_05
        else $error("receive ready missing after character");

    a_rx_off_zero: assert property ((rd_status && !i_rx_enabled) |=> !o_rd_data[0]) // RULE_05
        else $error("receive ready shown while disabled");

    a_tx_enable_now: assert property (($rose(i_tx_enabled) && !i_tx_holding_full && !break_pend_q) // RULE_08
        |-> tx_free)
        else $error("transmit ready late after enable");

    a_break_blocks_tx: assert property (i_break_start_cmd |=> !tx_free) // RULE_07
        else $error("transmit ready high with break pending");

    a_err_sticky: assert property ((sticky_q[usf_pkg::BIT_OVERRUN] && !i_status_clear_cmd) // RULE_12
        |=> sticky_q[usf_pkg::BIT_OVERRUN])
        else $error("overrun flag dropped without clear");

    a_clear_group: assert property ((i_status_clear_cmd && !i_rx_break_seen && !i_rx_overrun_err // RULE_22
        && !i_rx_frame_err && !i_parity_err) |=> (sticky_q[7:5] == 3'h0) && !sticky_q[2])
        else $error("status clear left an error flag set");

    a_timeout_zero: assert property (i_timeout_zero |-> !status_now[usf_pkg::BIT_TIMEOUT]) // RULE_15
        else $error("timeout shown with zero value");

    a_drained_off: assert property ((rd_status && !i_tx_enabled) |=> !o_rd_data[9]) // RULE_16
        else $error("drained flag shown while disabled");

    a_dma_mirror: assert property (rd_status |=> (o_rd_data[4:3] == $past({i_tx_dma_end, i_rx_dma_end})) // RULE_10
        && (o_rd_data[12:11] == $past({i_rx_dma_buffer_full, i_tx_dma_buffer_empty}))) // RULE_11
        else $error("DMA mirror bits wrong");

    a_neg_ack_seen_hold: assert property ((sticky_q[usf_pkg::BIT_NEG_ACK] && !i_neg_ack_clear_cmd) // RULE_18
        |=> sticky_q[usf_pkg::BIT_NEG_ACK])
        else $error("negative acknowledge flag dropped");

    a_modem_change: assert property ((modem_change != 4'h0) |=> // RULE_19
        ((sticky_q[19:16] & $past(modem_change)) == $past(modem_change)))
        else $error("modem change not captured");

    a_modem_rd_clear: assert property ((rd_status && modem_change == 4'h0) |=> (sticky_q[19:16] == 4'h0)) // RULE_19
        else $error("status read did not clear change flags");

    a_pin_image: assert property ((modem_primed && $stable(i_modem_pins))[*3] // RULE_21
        |-> (status_now[23:20] == i_modem_pins))
        else $error("pin image differs from settled pin");

    c_irq_raise: cover property (!o_irq ##1 o_irq);
    c_clear_race: cover property (i_status_clear_cmd && i_rx_overrun_err);
    c_rx_reenable: cover property (!i_rx_enabled && sticky_q[0] ##1 i_rx_enabled);
    c_modem_read: cover property (sticky_q[16] && rd_status);

endmodule

// File: usf_pkg.sv
// Constants for the serial channel status and interrupt mask block.
// Assumes a 32-bit register port and the peripheral clock domain.
package usf_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_IRQ_SET = 32'hfffb_0008;
    localparam logic [31:0] ADDR_IRQ_CLR = 32'hfffb_000c;
    localparam logic [31:0] ADDR_MASK = 32'hfffb_0010;
    localparam logic [31:0] ADDR_STATUS = 32'hfffb_0014;

    // Bit positions in mask and status; image bits 20-23 are in status only
    localparam int BIT_RX_READY = 0;
    localparam int BIT_TX_FREE = 1;
    localparam int BIT_BREAK = 2;
    localparam int BIT_RX_DMA_END = 3;
    localparam int BIT_TX_DMA_END = 4;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_FRAME = 6;
    localparam int BIT_PARITY = 7;
    localparam int BIT_TIMEOUT = 8;
    localparam int BIT_TX_DRAINED = 9;
    localparam int BIT_REPEAT = 10;
    localparam int BIT_TX_BUF_EMPTY = 11;
    localparam int BIT_RX_BUF_FULL = 12;
    localparam int BIT_NEG_ACK = 13;
    localparam int BIT_CHG_LSB = 16;
    localparam int BIT_IMG_LSB = 20;

    // Modem lanes in order: ring, set ready, carrier, clear to send
    localparam int MODEM_LANES = 4;
    localparam int SYNC_STAGES = 2;

    // Field layouts and reset values
    localparam logic [31:0] MASK_VALID = 32'h000f_3fff;
    localparam logic [31:0] STICKY_BITS = 32'h000f_25e5;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] STICKY_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [2:0] PRIME_RST = 3'h0;
    localparam logic [3:0] MODEM_RST = 4'h0;

endpackage

// File: usf_modem_peer.sv
// Far-side model of the four modem input lines of the serial channel.
// Assumes the bench names the wanted levels; lines move away from any clock edge.
`timescale 1ns/1ps

module usf_modem_peer (
    input wire logic [3:0] i_want, // Levels the peer should show
    output logic [3:0] o_pins // Ring, set ready, carrier, clear to send
);
    // Lines settle 1.7 ns late so the synchroniser never sees an edge-aligned change
    initial o_pins = 4'h0;
    always @(i_want) begin
        o_pins <= #1.7 i_want;
    end
endmodule

// File: tb.sv
// Self-checking bench for the status flags and interrupt mask block.
// Assumes one 200 MHz clock; reads are scored by a queue of expected words.
`timescale 1ns/1ps

module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic rd_seen = 1'b0;
    logic irq;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] o_rd;
    logic [13:0] pul = 14'h0000;
    logic [12:0] lv = 13'h0000;
    logic [3:0] pins;
    logic [31:0] stk = 32'h0000_0000;
    logic [31:0] m = 32'h0000_0000;
    logic [31:0] r = 32'h0000_0013;
    logic pend = 1'b0;
    logic bp = 1'b0;
    logic [31:0] exp_q[$];
    int ebit[7] = '{2, 5, 6, 7, 8, 10, 13};
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;

    // Pulses: char, holding read, break cmd, break began, 7 events, clear, arm, neg_ack_seen clear
    // Levels: rx en, tx en, full, shift busy, timeout zero, 4 DMA, 4 modem wants
    usf_status_irq dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(o_rd), .o_irq(irq), .i_rx_enabled(lv[0]),
        .i_tx_enabled(lv[1]), .i_rx_char_done(pul[0]), .i_rx_holding_read(pul[1]),
        .i_tx_holding_full(lv[2]), .i_tx_shift_busy(lv[3]), .i_break_start_cmd(pul[2]),
        .i_break_started(pul[3]), .i_rx_break_seen(pul[4]), .i_rx_overrun_err(pul[5]),
        .i_rx_frame_err(pul[6]), .i_parity_err(pul[7]), .i_rx_timeout(pul[8]),
        .i_timeout_zero(lv[4]), .i_repeat_limit_hit(pul[9]), .i_neg_ack_seen(pul[10]),
        .i_status_clear_cmd(pul[11]), .i_timeout_arm_cmd(pul[12]), .i_neg_ack_clear_cmd(pul[13]),
        .i_rx_dma_end(lv[5]), .i_tx_dma_end(lv[6]), .i_rx_dma_buffer_full(lv[7]),
        .i_tx_dma_buffer_empty(lv[8]), .i_modem_pins(pins));
    usf_modem_peer peer_u (.i_want(lv[12:9]), .o_pins(pins));

    // Clock generator
    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected status word built from the bench's own view of every input
    function automatic logic [31:0] st_exp();
        logic [31:0] s;
        s = stk;
        s[0] = pend & lv[0];
        s[1] = lv[1] & ~lv[2] & ~bp;
        s[8] = stk[8] & ~lv[4];
        s[9] = lv[1] & ~lv[2] & ~lv[3];
        {s[4], s[3], s[12], s[11]} = {lv[6], lv[5], lv[7], lv[8]};
        s[23:20] = lv[12:9];
        return s;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a == usf_pkg::ADDR_IRQ_SET) m = m | (d & usf_pkg::MASK_VALID);
        if (a == usf_pkg::ADDR_IRQ_CLR) m = m & ~d;
    endtask

    // A status read hands back the old change bits and then clears them
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        if (a == usf_pkg::ADDR_STATUS) stk[19:16] = 4'h0;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        pul[k] <= 1'b1;
        @(posedge clk);
        pul[k] <= 1'b0;
        if (k == 0) pend = 1'b1;
        if (k == 1) pend = 1'b0;
        if (k == 2) bp = 1'b1;
        if (k == 3) bp = 1'b0;
        if (k >= 4 && k <= 10) stk[ebit[k-4]] = 1'b1;
        if (k == 11) stk = stk & ~32'h0000_04e4;
        if (k == 12) stk[8] = 1'b0;
        if (k == 13) stk[13] = 1'b0;
    endtask

    // Four idle cycles let the modem lines clear the synchroniser before any read
    task automatic setl(input logic [12:0] l);
        stk[19:16] = stk[19:16] | (l[12:9] ^ lv[12:9]);
        if (!l[1]) bp = 1'b0;
        @(posedge clk);
        lv <= l;
        repeat (4) @(posedge clk);
    endtask

    task automatic sts();
        rd(usf_pkg::ADDR_STATUS, st_exp());
    endtask

    // Read results appear one cycle after the strobe and are scored in order
    always @(posedge clk) begin
        rd_seen <= rd_en;
        if (rd_seen) chk(o_rd, exp_q.pop_front(), "read data");
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(usf_pkg::ADDR_MASK, 32'h0000_0000);
        rd(usf_pkg::ADDR_IRQ_SET, 32'h0000_0000);
        rd(usf_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
        rd(32'hfffb_0018, 32'h0000_0000);
        sts();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            wr(usf_pkg::ADDR_IRQ_SET, r);
            r = lfsr(r);
            wr(usf_pkg::ADDR_IRQ_CLR, r);
            wr(usf_pkg::ADDR_MASK, r);
            wr(usf_pkg::ADDR_STATUS, r);
            rd(usf_pkg::ADDR_MASK, m);
        end
        wr(usf_pkg::ADDR_IRQ_CLR, 32'hffff_ffff);
        rd(usf_pkg::ADDR_MASK, 32'h0000_0000);
        $display("test mask done");
        setl(lv | 13'h0001);
        pulse(0);
        sts();
        setl(lv & ~13'h0001);
        sts();
        setl(lv | 13'h0001);
        sts();
        pulse(1);
        sts();
        setl(lv | 13'h0002);
        sts();
        setl(lv | 13'h0004);
        sts();
        setl(lv & ~13'h0004);
        pulse(2);
        sts();
        pulse(3);
        setl(lv | 13'h0008);
        sts();
        setl(lv & ~13'h0008);
        $display("test ready flags done");
        for (int i = 0; i < 16; i++) begin
            setl({lv[12:9], i[3:0], lv[4:0]});
            sts();
        end
        $display("test dma mirrors done");
        for (int i = 4; i <= 10; i++) begin
            pulse(i);
            sts();
        end
        pulse(13);
        sts();
        pulse(11);
        sts();
        setl(lv | 13'h0010);
        sts();
        setl(lv & ~13'h0010);
        pulse(12);
        sts();
        $display("test sticky flags done");
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            setl({r[3:0], lv[8:0]});
            sts();
            sts();
        end
        $display("test modem lines done");
        wr(usf_pkg::ADDR_IRQ_SET, 32'h0000_0020);
        pulse(5);
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, |(st_exp() & m)}, "irq raised");
        wr(usf_pkg::ADDR_IRQ_CLR, 32'h0000_0020);
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, |(st_exp() & m)}, "irq masked");
        wr(usf_pkg::ADDR_IRQ_SET, 32'h0000_0020);
        pulse(11);
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, |(st_exp() & m)}, "irq cleared");
        $display("test interrupt done");
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule
